// ===== core/uft_pkg.sv
// Shared constants and types for the USB host frame timing unit.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package uft_pkg;

    localparam logic [31:0] ADDR_FM_INTERVAL = 32'h9010_1034;
    localparam logic [31:0] ADDR_FM_REMAINING = 32'h9010_1038;
    localparam logic [31:0] ADDR_FM_NUMBER = 32'h9010_103C;
    localparam logic [31:0] ADDR_CTRL = 32'h9010_1100;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h9010_1104;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h9010_1108;

    localparam int FI_W = 14;
    localparam int FS_LARGEST_PACKET_W = 15;
    localparam int FN_W = 16;
    localparam int IRQ_W = 2;

    localparam int TOGGLE_BIT = 31;
    localparam int FS_LARGEST_PACKET_LSB = 16;
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int IRQ_SOF_BIT = 0;
    localparam int IRQ_WRAP_BIT = 1;

    localparam logic [FI_W-1:0] FI_NOMINAL = 14'h2EDF;
    localparam logic [FS_LARGEST_PACKET_W-1:0] FS_LARGEST_PACKET_RESET = 15'h0000;
    localparam logic [FN_W-1:0] FN_MAX = 16'hFFFF;
    localparam logic [31:0] REM_RSV_MASK = 32'h7FFF_C000;
    localparam logic [31:0] FN_RSV_MASK = 32'hFFFF_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_SYS_HZ = 125_000_000;
    localparam int FS_BIT_RATE_HZ = 12_000_000;

    typedef struct packed {
        logic toggle;
        logic [FS_LARGEST_PACKET_W-1:0] largest;
        logic [FI_W-1:0] interval;
    } uft_interval_s;

    typedef struct packed {
        logic [FN_W-1:0] frame_number;
    } uft_hca_wr_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SOF,
        ST_HCA,
        ST_LIST
    } uft_seq_e;

endpackage

// ===== core/uft_bit_tick.sv
// Fractional rate divider giving a one-cycle full-speed bit-time tick.
// Assumes TICK_HZ is below CLK_HZ; jitter is one system clock period.
`timescale 1ns/1ps
`default_nettype none
module uft_bit_tick #(
    parameter int CLK_HZ = uft_pkg::CLK_SYS_HZ,
    parameter int TICK_HZ = uft_pkg::FS_BIT_RATE_HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    output logic tick
);

    logic [31:0] acc_reg;
    logic [31:0] acc_sum;

    assign acc_sum = acc_reg + 32'(TICK_HZ);

    // Phase accumulator keeps the long-run rate exact
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_reg <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (acc_sum >= 32'(CLK_HZ)) begin
            acc_reg <= acc_sum - 32'(CLK_HZ);
            tick <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== core/uft_frame_timing.sv
// Frame timing unit: interval, remaining and frame number registers,
// start-of-frame sequencing and frame interrupt, behind AXI4-Lite.
// Assumes the SOF sender and memory writer share clk_sys.
// Operation
// (RULE_01) Interval field 14 bits, resets 0x2EDF
// (RULE_02) Reset command restores nominal interval
// (RULE_03) Software saves interval before reset command
// (RULE_04) Software flips toggle on each interval write
// (RULE_05) Largest-packet value loads counter each frame
// (RULE_06) Interval writes accepted at any time
// (RULE_07) Remaining counter decrements each bit time
// (RULE_08) Zero remaining reloads interval, starts frame
// (RULE_09) Toggle copied into remaining at reload
// (RULE_10) 16-bit frame number increments, wraps
// (RULE_11) Entering operation bumps frame number
// (RULE_12) SOF, then frame number write, then lists
// (RULE_13) Frame number written sets SOF flag
// (RULE_14) Bit-time enable at 12 Mbit/s
// (RULE_15) Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timing #(
    parameter int CLK_HZ = uft_pkg::CLK_SYS_HZ,
    parameter int BIT_HZ = uft_pkg::FS_BIT_RATE_HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sof_token_valid,
    input wire logic sof_token_ready,
    output logic hca_wr_valid,
    output uft_pkg::uft_hca_wr_s hca_wr,
    input wire logic hca_wr_ready,
    output logic ed_fetch_en,
    output logic [uft_pkg::FS_LARGEST_PACKET_W-1:0] largest_left,
    output logic irq
);

    logic aw_held_reg;
    logic [31:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic [31:0] wr_mask;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic rd_take;

    uft_pkg::uft_interval_s fm_int_reg;
    logic [uft_pkg::FI_W-1:0] rem_reg;
    logic rem_toggle_reg;
    logic [uft_pkg::FN_W-1:0] fn_reg;
    logic run_reg;
    logic run_d_reg;
    logic [uft_pkg::IRQ_W-1:0] irq_status_reg;
    logic [uft_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [uft_pkg::IRQ_W-1:0] irq_set;
    uft_pkg::uft_seq_e seq_reg;

    logic bit_en;
    logic run_rise;
    logic frame_start;
    logic ctrl_reset_pulse;
    logic wr_interval;

    uft_bit_tick #(
        .CLK_HZ(CLK_HZ),
        .TICK_HZ(BIT_HZ)
    ) u_bit_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(bit_en) // RULE_14
    );

    // Bus write channels: address and data are caught independently
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_mask[8*i +: 8] = {8{w_strb_reg[i]}};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0000_0000;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= uft_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_reg)
                    uft_pkg::ADDR_FM_INTERVAL,
                    uft_pkg::ADDR_FM_REMAINING,
                    uft_pkg::ADDR_FM_NUMBER,
                    uft_pkg::ADDR_CTRL,
                    uft_pkg::ADDR_IRQ_STATUS,
                    uft_pkg::ADDR_IRQ_MASK: begin
                        s_axi_bresp <= uft_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= uft_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_interval = do_write && aw_addr_reg == uft_pkg::ADDR_FM_INTERVAL;
    assign ctrl_reset_pulse = do_write && aw_addr_reg == uft_pkg::ADDR_CTRL
        && wr_mask[uft_pkg::CTRL_RESET_BIT]
        && w_data_reg[uft_pkg::CTRL_RESET_BIT];

    // Interval register; reserved bits 15:14 are simply not stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fm_int_reg.toggle <= 1'b0;
            fm_int_reg.largest <= uft_pkg::FS_LARGEST_PACKET_RESET;
            fm_int_reg.interval <= uft_pkg::FI_NOMINAL; // RULE_01
        end else if (ctrl_reset_pulse) begin
            fm_int_reg.interval <= uft_pkg::FI_NOMINAL; // RULE_02
        end else if (wr_interval) begin
            // No frame-boundary gating, so software can trim any time
            fm_int_reg <= uft_pkg::uft_interval_s'({ // RULE_06
                (w_data_reg[uft_pkg::TOGGLE_BIT:uft_pkg::FS_LARGEST_PACKET_LSB]
                    & wr_mask[uft_pkg::TOGGLE_BIT:uft_pkg::FS_LARGEST_PACKET_LSB])
                    | ({fm_int_reg.toggle, fm_int_reg.largest}
                    & ~wr_mask[uft_pkg::TOGGLE_BIT:uft_pkg::FS_LARGEST_PACKET_LSB]),
                (w_data_reg[uft_pkg::FI_W-1:0]
                    & wr_mask[uft_pkg::FI_W-1:0])
                    | (fm_int_reg.interval
                    & ~wr_mask[uft_pkg::FI_W-1:0])}); // RULE_15
        end
    end

    // Control: run level; the reset command bit is a write pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_reg <= 1'b0;
            irq_mask_reg <= '0;
        end else if (do_write && aw_addr_reg == uft_pkg::ADDR_CTRL
                && wr_mask[uft_pkg::CTRL_RUN_BIT]) begin
            run_reg <= w_data_reg[uft_pkg::CTRL_RUN_BIT];
        end else if (do_write && aw_addr_reg == uft_pkg::ADDR_IRQ_MASK) begin
            irq_mask_reg <= (w_data_reg[uft_pkg::IRQ_W-1:0]
                & wr_mask[uft_pkg::IRQ_W-1:0])
                | (irq_mask_reg & ~wr_mask[uft_pkg::IRQ_W-1:0]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_d_reg <= 1'b0;
        end else begin
            run_d_reg <= run_reg;
        end
    end

    assign run_rise = run_reg && !run_d_reg;
    assign frame_start = run_rise // RULE_11
        || (bit_en && run_reg && rem_reg == '0); // RULE_08

    // Frame counters
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rem_reg <= '0;
            rem_toggle_reg <= 1'b0;
            fn_reg <= '0;
            largest_left <= '0;
        end else begin
            if (frame_start) begin
                rem_reg <= fm_int_reg.interval; // RULE_08
                rem_toggle_reg <= fm_int_reg.toggle; // RULE_09
                fn_reg <= fn_reg + 16'h0001; // RULE_10
                largest_left <= fm_int_reg.largest; // RULE_05
            end else if (bit_en && run_reg) begin
                rem_reg <= rem_reg - 14'h0001; // RULE_07
                if (largest_left != '0) begin
                    largest_left <= largest_left - 15'h0001;
                end
            end
        end
    end

    // Per-frame sequence: token, frame number write, then list access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_reg <= uft_pkg::ST_IDLE;
            hca_wr <= '0;
        end else if (!run_reg) begin
            seq_reg <= uft_pkg::ST_IDLE;
        end else if (frame_start) begin
            seq_reg <= uft_pkg::ST_SOF;
        end else begin
            case (seq_reg)
                uft_pkg::ST_SOF: begin
                    if (sof_token_ready) begin
                        seq_reg <= uft_pkg::ST_HCA; // RULE_12
                        hca_wr.frame_number <= fn_reg;
                    end
                end
                uft_pkg::ST_HCA: begin
                    if (hca_wr_ready) begin
                        seq_reg <= uft_pkg::ST_LIST; // RULE_12
                    end
                end
                uft_pkg::ST_LIST: begin
                    seq_reg <= uft_pkg::ST_LIST;
                end
                default: begin
                    seq_reg <= uft_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign sof_token_valid = seq_reg == uft_pkg::ST_SOF;
    assign hca_wr_valid = seq_reg == uft_pkg::ST_HCA;
    assign ed_fetch_en = seq_reg == uft_pkg::ST_LIST;

    always_comb begin
        irq_set = '0;
        irq_set[uft_pkg::IRQ_SOF_BIT] = hca_wr_valid && hca_wr_ready
            && run_reg && !frame_start; // RULE_13
        irq_set[uft_pkg::IRQ_WRAP_BIT] = frame_start
            && fn_reg == uft_pkg::FN_MAX;
    end

    // Read clears status; an event in the same cycle survives
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status_reg <= '0;
        end else if (rd_take && s_axi_araddr == uft_pkg::ADDR_IRQ_STATUS) begin
            irq_status_reg <= irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read path
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            uft_pkg::ADDR_FM_INTERVAL: begin
                rd_mux[uft_pkg::TOGGLE_BIT:uft_pkg::FS_LARGEST_PACKET_LSB] =
                    {fm_int_reg.toggle, fm_int_reg.largest};
                rd_mux[uft_pkg::FI_W-1:0] = fm_int_reg.interval;
            end
            uft_pkg::ADDR_FM_REMAINING: begin
                rd_mux[uft_pkg::TOGGLE_BIT] = rem_toggle_reg;
                rd_mux[uft_pkg::FI_W-1:0] = rem_reg;
            end
            uft_pkg::ADDR_FM_NUMBER: begin
                rd_mux[uft_pkg::FN_W-1:0] = fn_reg;
            end
            uft_pkg::ADDR_CTRL: begin
                rd_mux[uft_pkg::CTRL_RUN_BIT] = run_reg;
            end
            uft_pkg::ADDR_IRQ_STATUS: begin
                rd_mux[uft_pkg::IRQ_W-1:0] = irq_status_reg;
            end
            uft_pkg::ADDR_IRQ_MASK: begin
                rd_mux[uft_pkg::IRQ_W-1:0] = irq_mask_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= uft_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? uft_pkg::RESP_OKAY : uft_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_fi_reset;
        @(posedge clk_sys) rst |=> fm_int_reg.interval == uft_pkg::FI_NOMINAL;
    endproperty
    a_fi_reset: assert property (p_fi_reset) // RULE_01
        else $error("interval not nominal after reset");

    property p_cmd_reset;
        @(posedge clk_sys) disable iff (rst)
        ctrl_reset_pulse |=> fm_int_reg.interval == uft_pkg::FI_NOMINAL;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset) // RULE_02
        else $error("reset command did not restore interval");

    property p_fi_write;
        @(posedge clk_sys) disable iff (rst)
        wr_interval && !ctrl_reset_pulse && (&w_strb_reg)
        |=> fm_int_reg.interval == $past(w_data_reg[uft_pkg::FI_W-1:0]);
    endproperty
    a_fi_write: assert property (p_fi_write) // RULE_06
        else $error("interval write not taken");

    property p_largest_load;
        @(posedge clk_sys) disable iff (rst)
        frame_start |=> largest_left == $past(fm_int_reg.largest);
    endproperty
    a_largest_load: assert property (p_largest_load) // RULE_05
        else $error("largest packet counter not loaded");

    property p_rem_dec;
        @(posedge clk_sys) disable iff (rst)
        bit_en && run_reg && rem_reg != '0 && !run_rise
        |=> rem_reg == 14'($past(rem_reg) - 14'h0001);
    endproperty
    a_rem_dec: assert property (p_rem_dec) // RULE_07
        else $error("remaining counter did not decrement");

    property p_reload;
        @(posedge clk_sys) disable iff (rst)
        bit_en && run_reg && rem_reg == '0
        |=> rem_reg == $past(fm_int_reg.interval)
            && rem_toggle_reg == $past(fm_int_reg.toggle);
    endproperty
    a_reload: assert property (p_reload) // RULE_08 RULE_09
        else $error("reload or toggle copy missing");

    property p_fn_inc;
        @(posedge clk_sys) disable iff (rst)
        frame_start |=> fn_reg == 16'($past(fn_reg) + 16'h0001);
    endproperty
    a_fn_inc: assert property (p_fn_inc) // RULE_10
        else $error("frame number did not advance");

    property p_op_entry;
        @(posedge clk_sys) disable iff (rst)
        run_rise |=> fn_reg != $past(fn_reg) ##0 sof_token_valid;
    endproperty
    a_op_entry: assert property (p_op_entry) // RULE_11
        else $error("entering operation did not start frame");

    sequence s_sof_taken;
        sof_token_valid && sof_token_ready && run_reg && !frame_start;
    endsequence
    sequence s_hca_taken;
        hca_wr_valid && hca_wr_ready && run_reg && !frame_start;
    endsequence

    property p_order;
        @(posedge clk_sys) disable iff (rst)
        s_sof_taken |=> hca_wr_valid && !ed_fetch_en
            && hca_wr.frame_number == fn_reg;
    endproperty
    a_order: assert property (p_order) // RULE_12
        else $error("frame number write not after token");

    property p_sof_flag;
        @(posedge clk_sys) disable iff (rst)
        s_hca_taken |=> irq_status_reg[uft_pkg::IRQ_SOF_BIT] ##0 ed_fetch_en;
    endproperty
    a_sof_flag: assert property (p_sof_flag) // RULE_13
        else $error("SOF flag not set after write");

    property p_bit_en;
        @(posedge clk_sys) disable iff (rst)
        bit_en |=> !bit_en ##1 !bit_en ##1 !bit_en ##1 !bit_en;
    endproperty
    a_bit_en: assert property (p_bit_en) // RULE_14
        else $error("bit enable too fast");

    property p_reserved;
        @(posedge clk_sys) disable iff (rst)
        rd_take && (s_axi_araddr == uft_pkg::ADDR_FM_REMAINING
            || s_axi_araddr == uft_pkg::ADDR_FM_NUMBER)
        |=> (s_axi_rdata
            & ($past(s_axi_araddr) == uft_pkg::ADDR_FM_NUMBER ?
            uft_pkg::FN_RSV_MASK : uft_pkg::REM_RSV_MASK)) == '0;
    endproperty
    a_reserved: assert property (p_reserved) // RULE_15
        else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// ===== test/uft_far_model.sv
// Far-side model of the frame timing unit: SOF sender and memory writer.
// Assumes the unit's clock; slow mode makes each request wait four cycles.
`timescale 1ns/1ps
`default_nettype none
module uft_far_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic sof_token_valid,
    output logic sof_token_ready,
    input wire logic hca_wr_valid,
    input wire uft_pkg::uft_hca_wr_s hca_wr,
    output logic hca_wr_ready,
    input wire logic ed_fetch_en,
    input wire logic [uft_pkg::FS_LARGEST_PACKET_W-1:0] largest_left,
    output logic [15:0] fn_seen,
    output logic [14:0] lg_seen,
    output int n_sof,
    output int gap,
    output int n_err
);
    int cyc;
    int t0;
    logic [2:0] wt;
    logic tok_done;
    logic tok_prev;

    // Slow answers force the unit to hold its requests
    assign sof_token_ready = sof_token_valid && (!slow || wt == 3'h4);
    assign hca_wr_ready = hca_wr_valid && (!slow || wt == 3'h4);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cyc <= 0;
            t0 <= 0;
            wt <= 3'h0;
            tok_done <= 1'b0;
            tok_prev <= 1'b0;
            fn_seen <= 16'h0000;
            lg_seen <= 15'h0000;
            n_sof <= 0;
            gap <= 0;
            n_err <= 0;
        end else begin
            cyc <= cyc + 1;
            tok_prev <= sof_token_valid;
            if ((sof_token_valid && !sof_token_ready) ||
                (hca_wr_valid && !hca_wr_ready)) begin
                wt <= wt + 3'h1;
            end else begin
                wt <= 3'h0;
            end
            if (sof_token_valid && !tok_prev) begin
                n_sof <= n_sof + 1;
                gap <= cyc - t0;
                t0 <= cyc;
                lg_seen <= largest_left;
            end
            if (sof_token_valid && sof_token_ready) begin
                tok_done <= 1'b1;
            end
            if (hca_wr_valid && hca_wr_ready) begin
                fn_seen <= hca_wr.frame_number;
                tok_done <= 1'b0;
            end
            // Memory write only after the token, lists never while the token is pending
            if ((hca_wr_valid && !tok_done) ||
                (ed_fetch_en && sof_token_valid)) begin
                n_err <= n_err + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/usb_host_frame_timing_test.sv
// Self-checking bench for the frame timing unit over AXI4-Lite.
// Assumes uft_pkg, uft_frame_timing and uft_far_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module usb_host_frame_timing_test;
    // Faster bit rate keeps frames short; one tick every DIV cycles
    localparam int DIV = 5;
    localparam int TIMEOUT = 20000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic sof_token_valid, sof_token_ready, hca_wr_valid, hca_wr_ready;
    uft_pkg::uft_hca_wr_s hca_wr;
    logic ed_fetch_en, irq, slow = 1'b0;
    logic [uft_pkg::FS_LARGEST_PACKET_W-1:0] largest_left;
    logic [15:0] fn_seen;
    logic [14:0] lg_seen;
    int n_sof, gap, n_err, cycles = 0, n_fail = 0, cmp_count = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #4 clk_sys = ~clk_sys;

    uft_frame_timing #(.CLK_HZ(125_000_000), .BIT_HZ(25_000_000)) i_dut (
        .clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sof_token_valid(sof_token_valid),
        .sof_token_ready(sof_token_ready), .hca_wr_valid(hca_wr_valid),
        .hca_wr(hca_wr), .hca_wr_ready(hca_wr_ready),
        .ed_fetch_en(ed_fetch_en), .largest_left(largest_left), .irq(irq));

    uft_far_model i_far (
        .clk_sys(clk_sys), .rst(rst), .slow(slow),
        .sof_token_valid(sof_token_valid), .sof_token_ready(sof_token_ready),
        .hca_wr_valid(hca_wr_valid), .hca_wr(hca_wr),
        .hca_wr_ready(hca_wr_ready), .ed_fetch_en(ed_fetch_en),
        .largest_left(largest_left), .fn_seen(fn_seen), .lg_seen(lg_seen),
        .n_sof(n_sof), .gap(gap), .n_err(n_err));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        int t;
        logic aw_ok;
        logic w_ok;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok && s_axi_bvalid) && t < 50);
        chk({30'h0, s_axi_bresp}, 32'h0, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        int t;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (!s_axi_rvalid && t < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(32'(t < 50), 32'h1, "read answer");
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp,
                       input string m);
        rd(a);
        chk(d, exp, m);
    endtask

    task automatic wait_frame(input int n);
        int t;
        t = 0;
        while ((n_sof < n || !ed_fetch_en) && t < 2000) begin
            @(posedge clk_sys);
            t++;
        end
        chk(32'(t < 2000), 32'h1, "frame sequence");
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            n_fail++;
            $display("[ERR] %0t run took too long", $time);
            stop_test;
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(uft_pkg::ADDR_FM_INTERVAL, 32'h0000_2EDF, "interval");
        rdc(uft_pkg::ADDR_FM_REMAINING, 32'h0, "remaining");
        rdc(uft_pkg::ADDR_FM_NUMBER, 32'h0, "number");
        rd(32'h9010_1200);
        chk(32'(r), 32'(uft_pkg::RESP_SLVERR), "unmapped read");
        // Reserved bits 15:14 set on purpose; largest packet 5, interval 20
        wr(uft_pkg::ADDR_FM_INTERVAL, 32'h0005_C014);
        rdc(uft_pkg::ADDR_FM_INTERVAL, 32'h0005_0014, "reserved");
        wr(uft_pkg::ADDR_CTRL, 32'h1);
        rdc(uft_pkg::ADDR_FM_INTERVAL, 32'h0005_2EDF, "reset cmd");
        wr(uft_pkg::ADDR_FM_INTERVAL, 32'h8005_0014);
        wr(uft_pkg::ADDR_FM_REMAINING, 32'hFFFF_FFFF);
        wr(uft_pkg::ADDR_FM_NUMBER, 32'hFFFF_FFFF);
        rdc(uft_pkg::ADDR_FM_REMAINING, 32'h0, "ro remaining");
        rdc(uft_pkg::ADDR_FM_NUMBER, 32'h0, "ro number");
        wr(uft_pkg::ADDR_IRQ_MASK, 32'h1);
        wr(uft_pkg::ADDR_CTRL, 32'h2);
        wait_frame(1);
        chk(32'(fn_seen), 32'h1, "first number");
        chk(32'(irq), 32'h1, "irq on sof");
        rdc(uft_pkg::ADDR_IRQ_STATUS, 32'h1, "status");
        rdc(uft_pkg::ADDR_IRQ_STATUS, 32'h0, "status cleared");
        chk(32'(irq), 32'h0, "irq cleared");
        wait_frame(3);
        chk(32'(gap), 32'(21 * DIV), "frame length");
        chk(32'(lg_seen), 32'h5, "largest load");
        chk(32'(fn_seen), 32'h3, "number in memory");
        rdc(uft_pkg::ADDR_FM_NUMBER, 32'h3, "number reg");
        rd(uft_pkg::ADDR_FM_REMAINING);
        chk(32'(d[31:14]), 32'h2_0000, "toggle copied");
        chk(32'(d[13:0] <= 14'h0014), 32'h1, "remaining range");
        slow <= 1'b1;
        wr(uft_pkg::ADDR_FM_INTERVAL, 32'h0005_001E);
        wait_frame(6);
        chk(32'(gap), 32'(31 * DIV), "new length");
        rd(uft_pkg::ADDR_FM_REMAINING);
        chk(32'(d[31]), 32'h0, "toggle cleared");
        chk(32'(n_err), 32'h0, "sequence order");
        wr(uft_pkg::ADDR_IRQ_MASK, 32'h0);
        rd(uft_pkg::ADDR_IRQ_STATUS);
        wait_frame(7);
        repeat (2) @(posedge clk_sys);
        chk(32'(irq), 32'h0, "masked irq");
        rdc(uft_pkg::ADDR_IRQ_STATUS, 32'h1, "masked status");
        stop_test;
    end
endmodule
`default_nettype wire
